// *** core/rtcrb_regs.vh ***
/*
  Constants of the real-time counter register bank: register indices, field positions,
  reset values and timing counts.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef RTCRB_REGS_VH
`define RTCRB_REGS_VH

// ----------------------------------------------------------------
// Register indices, byte address is four times the index
// ----------------------------------------------------------------
`define RTCRB_IX_CTRL     5'h00
`define RTCRB_IX_STAT     5'h01
`define RTCRB_IX_IEN      5'h02
`define RTCRB_IX_IFLG     5'h03
`define RTCRB_IX_TEMP     5'h04
`define RTCRB_IX_DBG      5'h05
`define RTCRB_IX_FREQUENCY_CALIBRATION    5'h06
`define RTCRB_IX_CSRC     5'h07
`define RTCRB_IX_CNTL     5'h08
`define RTCRB_IX_CNTH     5'h09
`define RTCRB_IX_PERL     5'h0A
`define RTCRB_IX_PERH     5'h0B
`define RTCRB_IX_CMPL     5'h0C
`define RTCRB_IX_CMPH     5'h0D
`define RTCRB_IX_PCTRL    5'h10
`define RTCRB_IX_PSTAT    5'h11
`define RTCRB_IX_PIEN     5'h12
`define RTCRB_IX_PIFLG    5'h13
`define RTCRB_IX_PDBG     5'h15

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define RTCRB_CTRL_EN     0
`define RTCRB_CTRL_CORR   2
`define RTCRB_CTRL_PSC_LO 3
`define RTCRB_CTRL_PSC_HI 6
`define RTCRB_CTRL_STBY   7
`define RTCRB_CTRL_MASK   8'hFD
`define RTCRB_FLG_OVF     0
`define RTCRB_FLG_CMP     1
`define RTCRB_FREQUENCY_CALIBRATION_SIGN  7
`define RTCRB_CSRC_MASK   8'h03
`define RTCRB_PCTRL_MASK  8'h79
`define RTCRB_BUSY_CTRL   0
`define RTCRB_BUSY_CNT    1
`define RTCRB_BUSY_PER    2
`define RTCRB_BUSY_CMP    3
`define RTCRB_BUSY_PIT    4

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define RTCRB_RST_BYTE    8'h00
`define RTCRB_RST_PER     16'hFFFF
`define RTCRB_RST_WORD    16'h0000
`define RTCRB_SYNC_TICKS  2'h2
`define RTCRB_PPM_SPAN    21'hF4240
`define RTCRB_PIT_RSVD    4'hF

`endif

// *** core/rtcrb_core.v ***
/*
  Real-time counter register bank with prescaler, crystal correction, wrap and compare
  flags, shared temporary byte and periodic interrupt timer, behind an AXI4-Lite slave.
  Assumes one clock mclk; the counter clock arrives as the one-cycle pulse counterTick,
  and standby and debug halt arrive as synchronous levels.
*/
// How it works
// - Prescaler field bits 6:3 divides the counter clock by two to that power.
// - A new prescaler setting takes effect two counter clock ticks after the write.
// - Bit 7 keeps the counter running in standby; clear stops it there.
// - Bit 2 enables frequency correction of the prescaler.
// - Bit 0 enables the counter; the periodic timer runs on its own enable, PCTRL bit 0.
// - Status bits 3..0 show compare, period, count, main-control busy while carried over.
// - Interrupt enable bit 0 overflow, bit 1 compare; only enabled sources request.
// - Compare flag bit 1 sets when counter equals compare value.
// - Counter at period value wraps to zero on next count.
// - Overflow flag bit 0 sets when counter reaches period and wraps.
// - Writing 1 clears a flag bit; writing 0 leaves it.
// - One shared temporary byte makes two byte accesses of 16-bit registers atomic.
// - The temporary byte is directly readable and writable at its own offset.
// - Debug-run clear and processor halted stops the counter; set keeps it running.
// - Correction adds or removes error-value cycles per million counter cycles.
// - Calibration sign 0 counts slower, 1 counts faster.
// - Periodic period 0 off, 1 gives 4 cycles, doubling to 32768 at 0xE, 0xF reserved.
`include "rtcrb_regs.vh"

module rtcrb_core #(
  parameter AW = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  // Counter clock and system state
  input wire counterTick,
  input wire standbySleep,
  input wire debugHalt,
  // AXI4-Lite write
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  // Events and interrupt
  output reg wrapOverflowEvt,
  output reg compareMatchEvt,
  output reg irq
);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire [4:0] wIx = s_axi_awaddr[6:2];
  wire [4:0] rIx = s_axi_araddr[6:2];
  wire wGo = s_axi_awvalid && s_axi_wvalid && !s_axi_awready && !s_axi_bvalid;
  wire rGo = s_axi_arvalid && !s_axi_arready && !s_axi_rvalid;
  wire wEn = wGo && s_axi_wstrb[0] && (s_axi_awaddr[AW-1:7] == 0);
  wire rEn = rGo && (s_axi_araddr[AW-1:7] == 0);
  wire [7:0] wd = s_axi_wdata[7:0];

  function mapped;
    input [4:0] ix;
    begin
      mapped = (ix <= `RTCRB_IX_CMPH) || (ix >= `RTCRB_IX_PCTRL && ix != 5'h14 &&
        ix <= `RTCRB_IX_PDBG);
    end
  endfunction

  // ----------------------------------------------------------------
  // Software-visible state
  // ----------------------------------------------------------------
  reg [7:0] ctrlShadow_r, ctrlEff_r, intEn_r, temp_r, frequency_calibration_r, clkSrc_r;
  reg [7:0] pitCtrlShadow_r, pitCtrlEff_r;
  reg debug_run_r, pitDbgRun_r, pitIntEn_r, pitFlag_r;
  reg [1:0] flags_r;
  reg [15:0] cntPend_r, cnt_r, perPend_r, perEff_r, cmpPend_r, cmpEff_r;
  reg [14:0] psc_r;
  reg [20:0] ppmAcc_r;
  reg corrPend_r, pitOut_r;

  // ----------------------------------------------------------------
  // Synchronisation busy channels
  // ----------------------------------------------------------------
  wire [4:0] syncWr;
  wire [4:0] syncDone;
  reg [4:0] busy_r;
  reg [9:0] age_r;
  assign syncWr[`RTCRB_BUSY_CTRL] = wEn && wIx == `RTCRB_IX_CTRL;
  assign syncWr[`RTCRB_BUSY_CNT] = wEn && wIx == `RTCRB_IX_CNTH;
  assign syncWr[`RTCRB_BUSY_PER] = wEn && wIx == `RTCRB_IX_PERH;
  assign syncWr[`RTCRB_BUSY_CMP] = wEn && wIx == `RTCRB_IX_CMPH;
  assign syncWr[`RTCRB_BUSY_PIT] = wEn && wIx == `RTCRB_IX_PCTRL;

  genvar g;
  generate
    for (g = 0; g < 5; g = g + 1) begin : gSync
      // A value is released after two counter ticks; a fresh write restarts the wait.
      assign syncDone[g] = busy_r[g] && counterTick && !syncWr[g] &&
        (age_r[2*g+:2] == `RTCRB_SYNC_TICKS - 2'h1);
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          busy_r[g] <= 1'b0;
          age_r[2*g+:2] <= 2'h0;
        end else if (syncWr[g]) begin
          busy_r[g] <= 1'b1;
          age_r[2*g+:2] <= 2'h0;
        end else if (syncDone[g]) begin
          busy_r[g] <= 1'b0;
        end else if (busy_r[g] && counterTick) begin
          age_r[2*g+:2] <= age_r[2*g+:2] + 2'h1;
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Prescaler with crystal correction
  // ----------------------------------------------------------------
  wire [3:0] pscSel = ctrlEff_r[`RTCRB_CTRL_PSC_HI:`RTCRB_CTRL_PSC_LO];
  wire rtcOn = ctrlEff_r[`RTCRB_CTRL_EN];
  wire pitOn = pitCtrlEff_r[0];
  wire rtcRun = rtcOn && !(standbySleep && !ctrlEff_r[`RTCRB_CTRL_STBY]) &&
    !(debugHalt && !debug_run_r);
  wire pitRun = pitOn && !(debugHalt && !pitDbgRun_r);
  wire pscRun = counterTick && ((rtcOn && rtcRun) || pitRun);
  wire corrOn = ctrlEff_r[`RTCRB_CTRL_CORR] || corrPend_r;
  wire [20:0] ppmSum = ppmAcc_r + {14'h0, frequency_calibration_r[6:0]};
  wire corrHit = corrOn && (ppmSum >= `RTCRB_PPM_SPAN);
  // Positive correction holds the prescaler one tick, negative steps it twice.
  wire [14:0] pscStep = !corrHit ? 15'h1 :
    (frequency_calibration_r[`RTCRB_FREQUENCY_CALIBRATION_SIGN] ? 15'h2 : 15'h0);
  // The sum is one bit wider than the prescaler, so the carry out of the top stage
  // still yields a count tick at the largest division.
  wire [15:0] pscSum = {1'b0, psc_r} + {1'b0, pscStep};
  wire [14:0] pscNext = pscSum[14:0];
  wire [15:0] pscMask = (16'h0001 << pscSel) - 16'h0001;
  // A count tick is taken when the selected low bits roll over to zero.
  wire [15:0] pscCross = ({1'b0, psc_r} ^ pscSum) & ~pscMask;
  wire cntTick = pscRun && rtcRun && (pscSel == 4'h0 ? pscStep != 15'h0 :
    pscCross != 16'h0);

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      psc_r <= 15'h0;
      ppmAcc_r <= 21'h0;
      corrPend_r <= 1'b0;
    end else if (!rtcOn && !pitOn) begin
      psc_r <= 15'h0;
      ppmAcc_r <= 21'h0;
      corrPend_r <= 1'b0;
    end else if (pscRun) begin
      psc_r <= pscNext;
      // Turning correction off stops it at once; a correction already owed is not completed.
      if (corrOn) begin
        ppmAcc_r <= corrHit ? ppmSum - `RTCRB_PPM_SPAN : ppmSum;
        corrPend_r <= !ctrlEff_r[`RTCRB_CTRL_CORR] && !corrHit && ppmAcc_r != 21'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Counter, wrap and compare
  // ----------------------------------------------------------------
  wire atPer = cnt_r == perEff_r;
  wire [15:0] cntNext = atPer ? 16'h0 : cnt_r + 16'h1;
  wire cmpHit = cntTick && cntNext == cmpEff_r;
  wire ovfHit = cntTick && atPer;
  wire flgClr = wEn && wIx == `RTCRB_IX_IFLG;
  wire pitClr = wEn && wIx == `RTCRB_IX_PIFLG && wd[0];
  wire [3:0] pitSel = pitCtrlEff_r[6:3];
  // Period code n toggles on prescaler bit n, giving a full period of 2^(n+1) ticks.
  wire pitLevel = pitRun && pitSel != 4'h0 && pitSel != `RTCRB_PIT_RSVD &&
    psc_r[pitSel];
  wire pitRise = pitLevel && !pitOut_r;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cnt_r <= `RTCRB_RST_WORD;
      flags_r <= 2'h0;
      pitFlag_r <= 1'b0;
      pitOut_r <= 1'b0;
      ctrlEff_r <= `RTCRB_RST_BYTE;
      perEff_r <= `RTCRB_RST_PER;
      cmpEff_r <= `RTCRB_RST_WORD;
      pitCtrlEff_r <= `RTCRB_RST_BYTE;
      wrapOverflowEvt <= 1'b0;
      compareMatchEvt <= 1'b0;
      irq <= 1'b0;
    end else begin
      if (syncDone[`RTCRB_BUSY_CTRL])
        ctrlEff_r <= ctrlShadow_r;
      if (syncDone[`RTCRB_BUSY_PER])
        perEff_r <= perPend_r;
      if (syncDone[`RTCRB_BUSY_CMP])
        cmpEff_r <= cmpPend_r;
      if (syncDone[`RTCRB_BUSY_PIT])
        pitCtrlEff_r <= pitCtrlShadow_r;
      if (syncDone[`RTCRB_BUSY_CNT])
        cnt_r <= cntPend_r;
      else if (cntTick)
        cnt_r <= cntNext;
      // A flag set in the same cycle as its clear survives.
      flags_r[`RTCRB_FLG_OVF] <= ovfHit ||
        (flags_r[`RTCRB_FLG_OVF] && !(flgClr && wd[`RTCRB_FLG_OVF]));
      flags_r[`RTCRB_FLG_CMP] <= cmpHit ||
        (flags_r[`RTCRB_FLG_CMP] && !(flgClr && wd[`RTCRB_FLG_CMP]));
      pitOut_r <= pitLevel;
      pitFlag_r <= pitRise || (pitFlag_r && !pitClr);
      wrapOverflowEvt <= ovfHit;
      compareMatchEvt <= cmpHit;
      irq <= |(flags_r & intEn_r[1:0]) || (pitFlag_r && pitIntEn_r);
    end
  end

  // ----------------------------------------------------------------
  // Register writes and the shared temporary byte
  // ----------------------------------------------------------------
  // Low-byte writes only park data in the temporary byte; the high-byte write commits
  // both halves at once, so the far side never sees a torn value.
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ctrlShadow_r <= `RTCRB_RST_BYTE;
      intEn_r <= `RTCRB_RST_BYTE;
      temp_r <= `RTCRB_RST_BYTE;
      frequency_calibration_r <= `RTCRB_RST_BYTE;
      clkSrc_r <= `RTCRB_RST_BYTE;
      pitCtrlShadow_r <= `RTCRB_RST_BYTE;
      debug_run_r <= 1'b0;
      pitDbgRun_r <= 1'b0;
      pitIntEn_r <= 1'b0;
      cntPend_r <= `RTCRB_RST_WORD;
      perPend_r <= `RTCRB_RST_PER;
      cmpPend_r <= `RTCRB_RST_WORD;
    end else if (wEn) begin
      case (wIx)
        `RTCRB_IX_CTRL: ctrlShadow_r <= wd & `RTCRB_CTRL_MASK;
        `RTCRB_IX_IEN: intEn_r <= {6'h0, wd[1:0]};
        `RTCRB_IX_TEMP: temp_r <= wd;
        `RTCRB_IX_DBG: debug_run_r <= wd[0];
        `RTCRB_IX_FREQUENCY_CALIBRATION: frequency_calibration_r <= wd;
        `RTCRB_IX_CSRC: clkSrc_r <= wd & `RTCRB_CSRC_MASK;
        `RTCRB_IX_CNTL, `RTCRB_IX_PERL, `RTCRB_IX_CMPL: temp_r <= wd;
        `RTCRB_IX_CNTH: cntPend_r <= {wd, temp_r};
        `RTCRB_IX_PERH: perPend_r <= {wd, temp_r};
        `RTCRB_IX_CMPH: cmpPend_r <= {wd, temp_r};
        `RTCRB_IX_PCTRL: pitCtrlShadow_r <= wd & `RTCRB_PCTRL_MASK;
        `RTCRB_IX_PIEN: pitIntEn_r <= wd[0];
        `RTCRB_IX_PDBG: pitDbgRun_r <= wd[0];
        default: ;
      endcase
    end else if (rEn) begin
      // Reading a low byte latches its high byte for the following access.
      case (rIx)
        `RTCRB_IX_CNTL: temp_r <= cnt_r[15:8];
        `RTCRB_IX_PERL: temp_r <= perPend_r[15:8];
        `RTCRB_IX_CMPL: temp_r <= cmpPend_r[15:8];
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Read mux
  // ----------------------------------------------------------------
  reg [7:0] rByte;
  always @* begin
    rByte = 8'h00;
    case (rIx)
      `RTCRB_IX_CTRL: rByte = ctrlShadow_r;
      `RTCRB_IX_STAT: rByte = {4'h0, busy_r[3:0]};
      `RTCRB_IX_IEN: rByte = intEn_r;
      `RTCRB_IX_IFLG: rByte = {6'h0, flags_r};
      `RTCRB_IX_TEMP: rByte = temp_r;
      `RTCRB_IX_DBG: rByte = {7'h0, debug_run_r};
      `RTCRB_IX_FREQUENCY_CALIBRATION: rByte = frequency_calibration_r;
      `RTCRB_IX_CSRC: rByte = clkSrc_r;
      `RTCRB_IX_CNTL: rByte = cnt_r[7:0];
      `RTCRB_IX_PERL: rByte = perPend_r[7:0];
      `RTCRB_IX_CMPL: rByte = cmpPend_r[7:0];
      `RTCRB_IX_CNTH, `RTCRB_IX_PERH, `RTCRB_IX_CMPH: rByte = temp_r;
      `RTCRB_IX_PCTRL: rByte = pitCtrlShadow_r;
      `RTCRB_IX_PSTAT: rByte = {7'h0, busy_r[`RTCRB_BUSY_PIT]};
      `RTCRB_IX_PIEN: rByte = {7'h0, pitIntEn_r};
      `RTCRB_IX_PIFLG: rByte = {7'h0, pitFlag_r};
      `RTCRB_IX_PDBG: rByte = {7'h0, pitDbgRun_r};
      default: rByte = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------
  // AXI4-Lite handshakes
  // ----------------------------------------------------------------
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0;
    end else begin
      s_axi_awready <= wGo;
      s_axi_wready <= wGo;
      // The answer waits one cycle for the address and data handshakes to finish, since
      // a response may not appear before both channels have been taken.
      if (wGo) begin
        s_axi_bresp <= (s_axi_awaddr[AW-1:7] == 0 && mapped(wIx)) ? 2'h0 : 2'h2;
      end
      if (s_axi_awready) begin
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= rGo;
      if (rGo) begin
        s_axi_rresp <= (rEn && mapped(rIx)) ? 2'h0 : 2'h2;
        s_axi_rdata <= rEn ? {24'h0, rByte} : 32'h0;
      end
      if (s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule // rtcrb_core

// *** tb/rtcrb_props.sv ***
/*
  Checker of the register bank ports: bus answers, held responses, events.
  Assumes binding to rtcrb_core, one clock mclk and reset rst active high.
*/
module rtcrb_props #(
  parameter AW = 8
) (
  // Clock and reset
  input wire mclk,
  input wire rst,
  input wire counterTick,
  // Write channels
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // Read channels
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  // Events
  input wire wrapOverflowEvt,
  input wire compareMatchEvt,
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_write_answer: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
    !s_axi_bvalid |=> (s_axi_awready && s_axi_wready && !s_axi_bvalid) ##1 s_axi_bvalid)
    else $error("write not answered in two cycles");
  a_read_answer: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid
    |=> (s_axi_arready && !s_axi_rvalid) ##1 s_axi_rvalid)
    else $error("read not answered in two cycles");
  a_bresp_held: assert property (s_axi_bvalid && !s_axi_bready
    |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_held: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_write_unmapped: assert property (s_axi_awvalid && s_axi_wvalid && !s_axi_awready &&
    !s_axi_bvalid && s_axi_awaddr[7] |=> s_axi_bresp == 2'h2) else $error("no write error");
  a_read_unmapped: assert property (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid &&
    s_axi_araddr[7] |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("no read error");
  a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_wrap_tick: assert property (wrapOverflowEvt |-> $past(counterTick))
    else $error("overflow event without tick");
  a_match_tick: assert property (compareMatchEvt |-> $past(counterTick))
    else $error("compare event without tick");

  c_wrap: cover property (wrapOverflowEvt);
  c_match: cover property (compareMatchEvt);
  c_irq: cover property ($rose(irq));
  c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule // rtcrb_props

bind rtcrb_core rtcrb_props #(.AW(AW)) chk (.mclk(mclk), .rst(rst), .counterTick(counterTick),
  .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .wrapOverflowEvt(wrapOverflowEvt), .compareMatchEvt(compareMatchEvt), .irq(irq));

// *** tb/test_rtc_control_register_bank.sv ***
/*
  Self-checking bench of the register bank: AXI4-Lite tasks and one task a scenario.
  Assumes rtcrb_core with the checker bound to it; counter ticks come every 4 cycles.
*/
module test_rtc_control_register_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0, rst = 1'b1, tick = 1'b0, standby = 1'b0, halted = 1'b0, tickOn = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd, rs;
  logic [3:0] wstrb = 4'hF;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, ovfEvt, cmpEvt, irq;
  logic [1:0] bresp, rresp, tdiv = 2'h0;
  int errors = 0, checked = 0;

  rtcrb_core #(.AW(8)) dut (
    .mclk(mclk), .rst(rst), .counterTick(tick), .standbySleep(standby), .debugHalt(halted),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wrapOverflowEvt(ovfEvt), .compareMatchEvt(cmpEvt), .irq(irq));

  always #2 mclk = ~mclk;
  // Ticks can be stopped so that busy flags stay up long enough to be read.
  always @(posedge mclk) begin
    tdiv <= tdiv + 2'h1;
    tick <= tickOn && tdiv == 2'h3;
  end

  // ----------------------------------------------------------------
  // Bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    awaddr <= a;
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge mclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    rs = {30'h0, bresp};
    bready <= 1'b0;
  endtask

  task automatic rdr(input logic [7:0] a);
    @(posedge mclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge mclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    rs = {30'h0, rresp};
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a);
    chk(rd, e);
  endtask

  // Software waits for the four STAT busy flags to clear before the next control write; the PIT busy flag is not polled.
  task automatic waitIdle;
    do rdr(8'h04); while (rd !== 32'h0);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testResetValues;
    logic [7:0] a[6] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
    foreach (a[i]) rchk(a[i], 32'h0);
    rchk(8'h28, 32'hFF);
    rchk(8'h2C, 32'hFF);
    $display("reset values done");
  endtask

  task automatic testTempBusy;
    logic [7:0] a[4] = '{8'h00, 8'h24, 8'h2C, 8'h34};
    wr(8'h10, 8'hA5);
    rchk(8'h10, 32'hA5);
    for (int i = 0; i < 4; i++) begin
      tickOn <= 1'b0;
      if (i > 0) wr(a[i] - 8'h04, 8'h5A);
      wr(a[i], 8'h00);
      rchk(8'h04, 32'h1 << i);
      tickOn <= 1'b1;
      waitIdle;
      if (i > 0) rchk(a[i] - 8'h04, 32'h5A);
      if (i > 0) rchk(a[i], 32'h0);
    end
    $display("temporary byte and busy flags done");
  endtask

  task automatic testUnmapped;
    logic [7:0] a[3] = '{8'h38, 8'h50, 8'h80};
    foreach (a[i]) begin
      wr(a[i], 8'hFF);
      chk(rs, 32'h2);
      rchk(a[i], 32'h0);
      chk(rs, 32'h2);
    end
    wr(8'h08, 8'hFF);
    rchk(8'h08, 32'h03);
    wr(8'h14, 8'hFF);
    rchk(8'h14, 32'h01);
    wr(8'h00, 8'hFE);
    rchk(8'h00, 32'hFC);
    waitIdle;
    $display("unmapped and unused bits done");
  endtask

  task automatic testCounting;
    // The count left by earlier scenarios lies above the new period and would first have
    // to run through the whole range, so it is cleared before counting starts.
    wr(8'h20, 8'h00);
    wr(8'h24, 8'h00);
    wr(8'h28, 8'h03);
    wr(8'h2C, 8'h00);
    wr(8'h30, 8'h02);
    wr(8'h34, 8'h00);
    wr(8'h00, 8'h01);
    waitIdle;
    halted <= 1'b1;
    wr(8'h0C, 8'h03);
    repeat (40) @(posedge mclk);
    rchk(8'h0C, 32'h03);
    chk({31'h0, irq}, 32'h1);
    wr(8'h14, 8'h00);
    repeat (8) @(posedge mclk);
    rdr(8'h20);
    chk({31'h0, rd < 32'h4}, 32'h1);
    wr(8'h0C, 8'h00);
    rchk(8'h0C, 32'h03);
    wr(8'h0C, 8'h01);
    rchk(8'h0C, 32'h02);
    wr(8'h08, 8'h01);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h0);
    wr(8'h0C, 8'h02);
    repeat (40) @(posedge mclk);
    rchk(8'h0C, 32'h0);
    halted <= 1'b0;
    standby <= 1'b1;
    repeat (40) @(posedge mclk);
    rchk(8'h0C, 32'h0);
    wr(8'h00, 8'h81);
    waitIdle;
    repeat (40) @(posedge mclk);
    rchk(8'h0C, 32'h03);
    standby <= 1'b0;
    $display("counting, flags and interrupt done");
  endtask

  task automatic testPrescaler;
    wr(8'h00, 8'h00);
    waitIdle;
    wr(8'h0C, 8'h03);
    repeat (40) @(posedge mclk);
    rchk(8'h0C, 32'h0);
    wr(8'h28, 8'hFF);
    wr(8'h2C, 8'hFF);
    wr(8'h20, 8'h00);
    wr(8'h24, 8'h00);
    waitIdle;
    wr(8'h00, 8'h19);
    rchk(8'h04, 32'h1);
    waitIdle;
    repeat (320) @(posedge mclk);
    rdr(8'h20);
    chk({31'h0, rd >= 32'h9 && rd <= 32'hC}, 32'h1);
    $display("prescaler done");
  endtask

  task automatic testPit;
    wr(8'h40, 8'h01);
    repeat (40) @(posedge mclk);
    rchk(8'h4C, 32'h0);
    wr(8'h40, 8'h09);
    repeat (40) @(posedge mclk);
    rchk(8'h4C, 32'h1);
    wr(8'h48, 8'h01);
    repeat (2) @(posedge mclk);
    chk({31'h0, irq}, 32'h1);
    halted <= 1'b1;
    wr(8'h4C, 8'h01);
    repeat (40) @(posedge mclk);
    rchk(8'h4C, 32'h0);
    chk({31'h0, irq}, 32'h0);
    halted <= 1'b0;
    $display("periodic timer done");
  endtask

  task automatic results;
    $display("counts: %0d checked, %0d errors", checked, errors);
    if (errors == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    testResetValues;
    testTempBusy;
    testUnmapped;
    testCounting;
    testPrescaler;
    testPit;
    results;
  end

  // The whole run needs about a thousand cycles; this limit only cuts a hang.
  initial begin
    repeat (20000) @(posedge mclk);
    errors++;
    results;
  end
endmodule // test_rtc_control_register_bank
